// ==== include/bper_pkg.sv ====
// Package of constants and types for the secondary-bus error reporting block
package bper_pkg;

  // ---------------------------------------------------------------
  // Register bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;                // Register address width
  localparam int DATA_W = 32;               // Register data width

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_CTRL     = 8'h00;  // Enables
  localparam logic [ADDR_W-1:0] A_PCI_STS  = 8'h04;  // Primary status flags
  localparam logic [ADDR_W-1:0] A_SEC_STS  = 8'h08;  // Secondary status flags
  localparam logic [ADDR_W-1:0] A_UNC_STS  = 8'h0c;  // Secondary uncorrectable status
  localparam logic [ADDR_W-1:0] A_UNC_MASK = 8'h10;  // Message mask, per error
  localparam logic [ADDR_W-1:0] A_UNC_SEV  = 8'h14;  // Severity, one is fatal
  localparam logic [ADDR_W-1:0] A_DEV_STS  = 8'h18;  // Fatal and non-fatal detected
  localparam logic [ADDR_W-1:0] A_INT_MASK = 8'h1c;  // Interrupt mask

  // ---------------------------------------------------------------
  // Register layouts, bit 0 is the last field
  // ---------------------------------------------------------------
  typedef struct packed {
    logic secondary_parity_response_enable;   // Bit 1
    logic system_error_report_enable;         // Bit 0
  } bper_ctrl_t;

  typedef struct packed {
    logic system_error_flag;                  // Bit 1, signaled system error
    logic detected_parity_error_flag;         // Bit 0
  } bper_pci_sts_t;

  typedef struct packed {
    logic received_system_error_flag;         // Bit 2
    logic sec_detected_parity_error_flag;     // Bit 1
    logic master_data_parity_flag;            // Bit 0
  } bper_sec_sts_t;

  typedef struct packed {
    logic system_error_asserted_flag;         // Bit 2
    logic parity_error_asserted_flag;         // Bit 1
    logic uncorrectable_data_flag;            // Bit 0
  } bper_unc_t;

  typedef struct packed {
    logic nonfatal_error_detected;            // Bit 1
    logic fatal_error_detected;               // Bit 0
  } bper_dev_sts_t;

  // ---------------------------------------------------------------
  // Event inputs from the forwarding datapath, same clock
  // ---------------------------------------------------------------
  typedef struct packed {
    logic pcie_imm_data_err;    // Data error on immediate completer response
    logic pci_np_wr_data_err;   // Data error on PCI-originated non-posted write
    logic pci_p_wr_data_err;    // Data error on PCI-originated posted write
    logic fwd_np_wr;            // Forwarding a non-posted write from PCIe
    logic fwd_p_wr;             // Forwarding a posted write from PCIe
    logic fwd_any;              // Forwarding any transaction from PCIe
  } bper_evt_t;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam bper_ctrl_t CTRL_RST     = 2'h0;  // All enables off
  localparam bper_unc_t  UNC_MASK_RST = 3'h0;  // Nothing masked
  localparam bper_unc_t  UNC_SEV_RST  = 3'h0;  // All non-fatal
  localparam bper_unc_t  INT_MASK_RST = 3'h0;  // Interrupts off

  // ---------------------------------------------------------------
  // Parity-error pin driver states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PERR_IDLE,     // Pin released
    PERR_DRIVE,    // Pin driven low
    PERR_HIGH      // Pin driven high for one cycle before release
  } bper_perr_st_t;

endpackage

// ==== verilog/bper_sticky.sv ====
// Sticky flag register, set by hardware, cleared by a read
`timescale 1ns/1ps
`default_nettype none

module bper_sticky #(
  parameter int WIDTH = 3                  // Number of flags
) (
  input  wire logic             ref_clk,   // Block clock
  input  wire logic             reset_n,   // Synchronous reset, active low
  input  wire logic [WIDTH-1:0] set,       // One-cycle set pulses
  input  wire logic             clr,       // Read of this register
  output logic      [WIDTH-1:0] q          // Stored flags
);

  // ---------------------------------------------------------------
  // Next value: a set in the clearing cycle survives
  // ---------------------------------------------------------------
  wire logic [WIDTH-1:0] next_q;           // Flags after this cycle
  assign next_q = set | (clr ? '0 : q);

  // Flag storage
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule

`default_nettype wire

// ==== verilog/bper_top.sv ====
// Secondary-bus parity and system error reporting for the bridge
//
// Behaviour
// R01 - Immediate-response data error sets primary parity flag
// R02 - Then drive parity pin only if response enabled
// R03 - Each error sets fatal or non-fatal detected
// R04 - Signaled system error needs message and enable
// R05 - Immediate error sets master parity, uncorrectable data
// R06 - Target parity on non-posted write logs flags
// R07 - Parity on posted write logs flags
// R08 - System error pin while forwarding logs flags
// R09 - PCI non-posted write error logs flags
// R10 - PCI posted write error drives pin if enabled
// R11 - PCI posted write error sets three flags
// R12 - Severity per error, masked errors send nothing
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module bper_top (
  input  wire logic                        ref_clk,               // 25 MHz clock
  input  wire logic                        reset_n,               // Sync reset
  input  wire logic [bper_pkg::ADDR_W-1:0] reg_addr,              // Register address
  input  wire logic [bper_pkg::DATA_W-1:0] reg_wdata,             // Write data
  input  wire logic                        reg_wr,                // Write strobe
  input  wire logic                        reg_rd,                // Read strobe
  output logic      [bper_pkg::DATA_W-1:0] reg_rdata,             // Read data
  input  wire bper_pkg::bper_evt_t         evt,                   // Datapath events
  input  wire logic                        parity_error_pin_in,   // Pin level
  output logic                             parity_error_pin_out,  // Pin drive value
  output logic                             parity_error_pin_oe_n, // Low while driving
  input  wire logic                        system_error_pin_in,   // Pin level
  output logic                             err_fatal_msg,         // Fatal message pulse
  output logic                             err_nonfatal_msg,      // Non-fatal message pulse
  output logic                             irq                    // Level interrupt
);

  // ---------------------------------------------------------------
  // Address match helper
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [bper_pkg::ADDR_W-1:0] a,
                               input logic [bper_pkg::ADDR_W-1:0] b);
    hit = (a == b);
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] pin_meta;     // First stage, read only by second stage
  logic [1:0] pin_sync;     // Second stage, bit 0 parity, bit 1 system
  logic [1:0] own_echo;     // Own low drive, delayed like the parity stages
  // Two flops on both bus error pins
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pin_meta <= 2'h3;
      pin_sync <= 2'h3;
      own_echo <= 2'h0;
    end else begin
      pin_meta <= {system_error_pin_in, parity_error_pin_in};
      pin_sync <= pin_meta;
      own_echo <= {own_echo[0], !parity_error_pin_oe_n && !parity_error_pin_out};
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  bper_pkg::bper_ctrl_t    ctrl;        // Enables
  bper_pkg::bper_unc_t     unc_mask;    // Message mask
  bper_pkg::bper_unc_t     unc_sev;     // Severity
  bper_pkg::bper_unc_t     int_mask;    // Interrupt mask
  bper_pkg::bper_pci_sts_t pci_sts;     // Primary status
  bper_pkg::bper_sec_sts_t sec_sts;     // Secondary status
  bper_pkg::bper_unc_t     unc_sts;     // Uncorrectable status
  bper_pkg::bper_dev_sts_t dev_sts;     // Device status

  // Address decode
  wire logic wr_ctrl;                   // Write enables
  wire logic wr_mask;
  wire logic wr_sev;
  wire logic wr_int;
  assign wr_ctrl = reg_wr && hit(reg_addr, bper_pkg::A_CTRL);
  assign wr_mask = reg_wr && hit(reg_addr, bper_pkg::A_UNC_MASK);
  assign wr_sev  = reg_wr && hit(reg_addr, bper_pkg::A_UNC_SEV);
  assign wr_int  = reg_wr && hit(reg_addr, bper_pkg::A_INT_MASK);

  wire logic rd_pci;                    // Read-clear strobes
  wire logic rd_sec;
  wire logic rd_unc;
  wire logic rd_dev;
  assign rd_pci = reg_rd && hit(reg_addr, bper_pkg::A_PCI_STS);
  assign rd_sec = reg_rd && hit(reg_addr, bper_pkg::A_SEC_STS);
  assign rd_unc = reg_rd && hit(reg_addr, bper_pkg::A_UNC_STS);
  assign rd_dev = reg_rd && hit(reg_addr, bper_pkg::A_DEV_STS);

  // Control registers, written whole
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ctrl     <= bper_pkg::CTRL_RST;
      unc_mask <= bper_pkg::UNC_MASK_RST;
      unc_sev  <= bper_pkg::UNC_SEV_RST;
      int_mask <= bper_pkg::INT_MASK_RST;
    end else begin
      if (wr_ctrl) ctrl     <= reg_wdata[$bits(ctrl)-1:0];
      if (wr_mask) unc_mask <= reg_wdata[$bits(unc_mask)-1:0];
      if (wr_sev)  unc_sev  <= reg_wdata[$bits(unc_sev)-1:0];
      if (wr_int)  int_mask <= reg_wdata[$bits(int_mask)-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Event qualification
  // ---------------------------------------------------------------
  bper_pkg::bper_perr_st_t perr_st;     // Pin driver state
  bper_pkg::bper_perr_st_t next_perr_st;

  wire logic spe;                       // Secondary parity response enable
  wire logic perr_seen;                 // Parity pin low from another agent
  wire logic ev_np_perr;                // Target parity error, non-posted
  wire logic ev_p_perr;                 // Target parity error, posted
  wire logic ev_serr;                   // System error pin seen
  assign spe        = ctrl.secondary_parity_response_enable;
  // Own drive returns through the stages two cycles late, not a target report
  assign perr_seen  = !pin_sync[0] && !own_echo[1];
  assign ev_np_perr = perr_seen && evt.fwd_np_wr;
  assign ev_p_perr  = perr_seen && evt.fwd_p_wr;
  assign ev_serr    = !pin_sync[1] && evt.fwd_any;

  // ---------------------------------------------------------------
  // Flag set terms
  // ---------------------------------------------------------------
  bper_pkg::bper_pci_sts_t pci_set;     // Primary status sets
  bper_pkg::bper_sec_sts_t sec_set;     // Secondary status sets
  bper_pkg::bper_unc_t     unc_set;     // Uncorrectable status sets
  bper_pkg::bper_dev_sts_t dev_set;     // Device status sets
  bper_pkg::bper_unc_t     unc_fatal;   // Errors classed fatal
  bper_pkg::bper_unc_t     unc_nonfatal;// Errors classed non-fatal
  wire logic next_fatal_msg;            // Unmasked fatal error present
  wire logic next_nonfatal_msg;         // Unmasked non-fatal error present
  // Primary parity flag
  assign pci_set.detected_parity_error_flag = evt.pcie_imm_data_err; // R01

  // Master data parity, only under response enable
  assign sec_set.master_data_parity_flag = spe && (evt.pcie_imm_data_err // R05
                                                   || ev_np_perr         // R06
                                                   || ev_p_perr          // R07
                                                   || evt.pci_p_wr_data_err); // R11
  // Secondary detected parity for PCI-originated writes
  assign sec_set.sec_detected_parity_error_flag = evt.pci_np_wr_data_err // R09
                                                || evt.pci_p_wr_data_err; // R11
  assign sec_set.received_system_error_flag = ev_serr; // R08

  // Uncorrectable status sets
  assign unc_set.uncorrectable_data_flag = evt.pcie_imm_data_err // R05
                                         || evt.pci_np_wr_data_err // R09
                                         || evt.pci_p_wr_data_err; // R11
  assign unc_set.parity_error_asserted_flag = ev_np_perr || ev_p_perr; // R06 R07
  assign unc_set.system_error_asserted_flag = ev_serr; // R08

  // Severity split and message gating
  assign unc_fatal    = unc_set & unc_sev; // R12
  assign unc_nonfatal = unc_set & ~unc_sev; // R12
  assign dev_set.fatal_error_detected    = |unc_fatal; // R03
  assign dev_set.nonfatal_error_detected = |unc_nonfatal; // R03
  assign next_fatal_msg    = |(unc_fatal & ~unc_mask); // R12
  assign next_nonfatal_msg = |(unc_nonfatal & ~unc_mask); // R12

  // Signaled system error follows a sent message
  assign pci_set.system_error_flag = (next_fatal_msg || next_nonfatal_msg) // R04
                                   && ctrl.system_error_report_enable; // R04

  // ---------------------------------------------------------------
  // Sticky status registers
  // ---------------------------------------------------------------
  // Primary status
  bper_sticky #(.WIDTH($bits(bper_pkg::bper_pci_sts_t))) u_pci_sts (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .set     (pci_set),
    .clr     (rd_pci),
    .q       (pci_sts)
  );

  // Secondary status
  bper_sticky #(.WIDTH($bits(bper_pkg::bper_sec_sts_t))) u_sec_sts (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .set     (sec_set),
    .clr     (rd_sec),
    .q       (sec_sts)
  );

  // Uncorrectable status, also the interrupt source
  bper_sticky #(.WIDTH($bits(bper_pkg::bper_unc_t))) u_unc_sts (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .set     (unc_set),
    .clr     (rd_unc),
    .q       (unc_sts)
  );

  // Device status
  bper_sticky #(.WIDTH($bits(bper_pkg::bper_dev_sts_t))) u_dev_sts (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .set     (dev_set),
    .clr     (rd_dev),
    .q       (dev_sts)
  );

  // ---------------------------------------------------------------
  // Error messages toward the link
  // ---------------------------------------------------------------
  // One-cycle pulses, one cycle after the error
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      err_fatal_msg    <= 1'b0;
      err_nonfatal_msg <= 1'b0;
    end else begin
      err_fatal_msg    <= next_fatal_msg; // R12
      err_nonfatal_msg <= next_nonfatal_msg; // R12
    end
  end

  // ---------------------------------------------------------------
  // Parity-error pin driver
  // ---------------------------------------------------------------
  wire logic perr_req;                  // Request to drive the pin low
  assign perr_req = spe && (evt.pcie_imm_data_err || evt.pci_p_wr_data_err); // R02 R10

  // Low for one cycle, high for one, then released
  always_comb begin
    case (perr_st)
      bper_pkg::PERR_IDLE: begin
        next_perr_st = perr_req ? bper_pkg::PERR_DRIVE : bper_pkg::PERR_IDLE;
      end
      bper_pkg::PERR_DRIVE: begin
        // A further error keeps the pin low
        next_perr_st = perr_req ? bper_pkg::PERR_DRIVE : bper_pkg::PERR_HIGH;
      end
      bper_pkg::PERR_HIGH: begin
        next_perr_st = perr_req ? bper_pkg::PERR_DRIVE : bper_pkg::PERR_IDLE;
      end
      default: begin
        next_perr_st = bper_pkg::PERR_IDLE;
      end
    endcase
  end

  // State and registered pin outputs
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      perr_st               <= bper_pkg::PERR_IDLE;
      parity_error_pin_out  <= 1'b1;
      parity_error_pin_oe_n <= 1'b1;
    end else begin
      perr_st               <= next_perr_st;
      parity_error_pin_out  <= (next_perr_st != bper_pkg::PERR_DRIVE);
      parity_error_pin_oe_n <= (next_perr_st == bper_pkg::PERR_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // Read data and interrupt
  // ---------------------------------------------------------------
  wire logic [bper_pkg::DATA_W-1:0] rd_mux;   // Selected register
  assign rd_mux =
    hit(reg_addr, bper_pkg::A_CTRL)     ? bper_pkg::DATA_W'(ctrl)     :
    hit(reg_addr, bper_pkg::A_PCI_STS)  ? bper_pkg::DATA_W'(pci_sts)  :
    hit(reg_addr, bper_pkg::A_SEC_STS)  ? bper_pkg::DATA_W'(sec_sts)  :
    hit(reg_addr, bper_pkg::A_UNC_STS)  ? bper_pkg::DATA_W'(unc_sts)  :
    hit(reg_addr, bper_pkg::A_UNC_MASK) ? bper_pkg::DATA_W'(unc_mask) :
    hit(reg_addr, bper_pkg::A_UNC_SEV)  ? bper_pkg::DATA_W'(unc_sev)  :
    hit(reg_addr, bper_pkg::A_DEV_STS)  ? bper_pkg::DATA_W'(dev_sts)  :
    hit(reg_addr, bper_pkg::A_INT_MASK) ? bper_pkg::DATA_W'(int_mask) :
    '0;

  // Data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

  // High while an unmasked uncorrectable flag stands
  assign irq = |(unc_sts & int_mask);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_imm_parity_flag: assert property ( // R01
    evt.pcie_imm_data_err |=> pci_sts.detected_parity_error_flag)
    else $error("Primary parity flag not set");

  a_pin_drive_imm: assert property ( // R02
    (evt.pcie_imm_data_err && spe) |=> (!parity_error_pin_out && !parity_error_pin_oe_n))
    else $error("Parity pin not driven low");

  a_pin_quiet_off: assert property ( // R02
    (perr_st == bper_pkg::PERR_IDLE && !spe) |=> parity_error_pin_oe_n)
    else $error("Parity pin driven while disabled");

  a_dev_detected: assert property ( // R03
    (|unc_set) |=> (dev_sts.fatal_error_detected || dev_sts.nonfatal_error_detected))
    else $error("No fatal or non-fatal flag");

  a_serr_needs_en: assert property ( // R04
    $rose(pci_sts.system_error_flag)
      |-> $past(ctrl.system_error_report_enable)
          && (err_fatal_msg || err_nonfatal_msg))
    else $error("Signaled system error without cause");

  a_imm_mdp: assert property ( // R05
    (evt.pcie_imm_data_err && spe)
      |=> (sec_sts.master_data_parity_flag && unc_sts.uncorrectable_data_flag))
    else $error("Immediate error flags missing");

  a_np_perr_flags: assert property ( // R06
    (ev_np_perr && spe)
      |=> (unc_sts.parity_error_asserted_flag && sec_sts.master_data_parity_flag))
    else $error("Non-posted parity flags missing");

  a_p_perr_flags: assert property ( // R07
    ev_p_perr |=> unc_sts.parity_error_asserted_flag)
    else $error("Posted parity flag missing");

  a_serr_flags: assert property ( // R08
    ev_serr
      |=> (sec_sts.received_system_error_flag && unc_sts.system_error_asserted_flag))
    else $error("System error flags missing");

  a_pci_np_flags: assert property ( // R09
    evt.pci_np_wr_data_err
      |=> (sec_sts.sec_detected_parity_error_flag && unc_sts.uncorrectable_data_flag))
    else $error("Non-posted write error flags missing");

  a_pci_p_pin: assert property ( // R10
    (evt.pci_p_wr_data_err && spe && perr_st == bper_pkg::PERR_IDLE)
      |=> !parity_error_pin_oe_n [*2])
    else $error("Parity pin drive too short");

  a_pci_p_flags: assert property ( // R11
    (evt.pci_p_wr_data_err && spe)
      |=> (sec_sts.sec_detected_parity_error_flag
           && sec_sts.master_data_parity_flag && unc_sts.uncorrectable_data_flag))
    else $error("Posted write error flags missing");

  a_msg_unmasked: assert property ( // R12
    err_fatal_msg |-> |(unc_sts & $past(unc_sev) & ~$past(unc_mask)))
    else $error("Fatal message for masked error");

  a_rdata_slot: assert property (
    !$past(reg_rd) |-> (reg_rdata == '0))
    else $error("Read data outside its cycle");

  c_pin_cycle: cover property (
    perr_req && perr_st == bper_pkg::PERR_IDLE ##1 !parity_error_pin_oe_n [*2]
      ##1 parity_error_pin_oe_n);
  c_fatal_msg: cover property (err_fatal_msg && pci_sts.system_error_flag);
  c_irq_clear: cover property (irq ##1 rd_unc ##1 !irq);
  c_set_on_clear: cover property (rd_unc && (|unc_set));

endmodule

`default_nettype wire

// ==== verification/bper_agents.sv ====
// Behavioural model of the agents on the secondary bus
`timescale 1ns/1ps
`default_nettype none

module bper_agents (
  input  wire logic perr_req,   // Agent pulls the parity pin low
  input  wire logic serr_req,   // Agent pulls the system error pin low
  input  wire logic drv_out,    // Bridge parity pin value
  input  wire logic drv_oe_n,   // Bridge enable, low drives
  output logic      perr_line,  // Resolved parity pin
  output logic      serr_line   // Resolved system error pin
);
  // Wired lines with pull-ups: any low driver wins
  assign perr_line = ~perr_req & (drv_oe_n | drv_out);
  assign serr_line = ~serr_req;
endmodule

`default_nettype wire

// ==== verification/test_bper_top.sv ====
// Self-checking bench for the secondary-bus error reporting block
`timescale 1ns/1ps
`default_nettype none

module test_bper_top;
  logic                        ref_clk = 1'b0;  // 25 MHz clock
  logic                        reset_n = 1'b0;  // Sync reset
  logic [7:0]                  reg_addr = 8'h00;
  logic [31:0]                 reg_wdata = 32'h0;
  logic                        reg_wr = 1'b0;
  logic                        reg_rd = 1'b0;
  logic [31:0]                 reg_rdata;
  bper_pkg::bper_evt_t         evt = 6'h00;     // Datapath events
  logic                        perr_req = 1'b0; // Agent parity report
  logic                        serr_req = 1'b0; // Agent system error
  logic                        pin_out, oe_n, perr_line, serr_line;
  logic                        fatal, nonfatal, irq;
  logic                        saw_fat, saw_nf, saw_drv; // Pulse catchers
  logic                        catch_clr = 1'b1; // Holds the catchers clear
  int                          num_errors = 0;
  int                          tests_run = 0;

  always #20 ref_clk = ~ref_clk;

  bper_top dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .evt(evt), .parity_error_pin_in(perr_line), .parity_error_pin_out(pin_out),
    .parity_error_pin_oe_n(oe_n), .system_error_pin_in(serr_line),
    .err_fatal_msg(fatal), .err_nonfatal_msg(nonfatal), .irq(irq));

  bper_agents agents_u (.perr_req(perr_req), .serr_req(serr_req), .drv_out(pin_out),
    .drv_oe_n(oe_n), .perr_line(perr_line), .serr_line(serr_line));

  // Catch one-cycle outputs between checks
  always @(posedge ref_clk) begin
    saw_fat <= !catch_clr && (saw_fat || fatal === 1'b1);
    saw_nf <= !catch_clr && (saw_nf || nonfatal === 1'b1);
    saw_drv <= !catch_clr && (saw_drv || (oe_n === 1'b0 && pin_out === 1'b0));
  end

  // Expected uncorrectable bit per event kind
  function automatic logic [2:0] unc_of(input int k);
    return (k < 3) ? 3'h1 : (k < 5) ? 3'h2 : 3'h4;
  endfunction
  // Expected secondary status per event kind
  function automatic logic [2:0] sec_of(input int k, input logic spe);
    return {k == 5, k == 1 || k == 2, spe && k != 1 && k != 5};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Read, data taken in the one cycle it stands
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(n, e, reg_rdata);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog, far beyond the expected run
  initial begin
    #2000000;
    num_errors++;
    test_done();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int k;
    logic spe, se;
    logic [2:0] sev, msk, imk, u;
    void'($urandom(50));
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    wr(bper_pkg::A_UNC_STS, 32'h7);
    for (int a = 0; a <= 32; a += 4) rc("reset", a[7:0], 32'h0);
    $display("test reset done");
    // Corner: an error in the cycle of the clearing read survives it
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= bper_pkg::A_UNC_STS;
    evt <= 6'h08;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    evt <= 6'h00;
    #1 chk("clear read", 32'h0, reg_rdata);
    rc("set wins", bper_pkg::A_UNC_STS, 32'h1);
    rc("set wins sec", bper_pkg::A_SEC_STS, 32'h2);
    rc("set wins dev", bper_pkg::A_DEV_STS, 32'h2);
    $display("test set on clear done");
    for (int i = 0; i < 24; i++) begin
      k = i % 6;
      spe = (i < 6) ? 1'b1 : 1'($urandom);
      se = 1'($urandom);
      sev = 3'($urandom);
      msk = (i < 6) ? 3'h0 : 3'($urandom);
      imk = 3'($urandom);
      u = unc_of(k);
      wr(bper_pkg::A_CTRL, {30'h0, spe, se});
      wr(bper_pkg::A_UNC_SEV, {29'h0, sev});
      wr(bper_pkg::A_UNC_MASK, {29'h0, msk});
      wr(bper_pkg::A_INT_MASK, {29'h0, imk});
      catch_clr <= 1'b1;
      @(posedge ref_clk);
      catch_clr <= 1'b0;
      evt <= (k < 3) ? 6'h20 >> k : (k == 3) ? 6'h05 : (k == 4) ? 6'h03 : 6'h01;
      perr_req <= (k == 3 || k == 4);
      serr_req <= (k == 5);
      @(posedge ref_clk);
      evt <= (k < 3) ? 6'h00 : evt;
      perr_req <= 1'b0;
      serr_req <= 1'b0;
      repeat (5) @(posedge ref_clk);
      evt <= 6'h00;
      repeat (2) @(posedge ref_clk);
      chk("irq", {31'h0, |(u & imk)}, {31'h0, irq});
      chk("pin", {31'h0, spe && (k == 0 || k == 2)}, {31'h0, saw_drv});
      chk("fatal", {31'h0, |(u & ~msk & sev)}, {31'h0, saw_fat});
      chk("nonfatal", {31'h0, |(u & ~msk & ~sev)}, {31'h0, saw_nf});
      rc("ctrl", bper_pkg::A_CTRL, {30'h0, spe, se});
      rc("pci", bper_pkg::A_PCI_STS, {30'h0, se && |(u & ~msk), k == 0});
      rc("sec", bper_pkg::A_SEC_STS, {29'h0, sec_of(k, spe)});
      rc("unc", bper_pkg::A_UNC_STS, {29'h0, u});
      rc("dev", bper_pkg::A_DEV_STS, {30'h0, ~|(u & sev), |(u & sev)});
      rc("unc clear", bper_pkg::A_UNC_STS, 32'h0);
      chk("irq clear", 32'h0, {31'h0, irq});
      $display("test %0d kind %0d done", i, k);
    end
    test_done();
  end
endmodule

`default_nettype wire
